// >>> rtl/phy_tenbase_power_crossover_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Link pulse enable set sends 10M link pulses; clear suppresses, forces link good
// - Cleared link pulse enable stops pulses and forces link good at 10M regardless of pulses seen
// - Heartbeat enable, reset 1, turns 10M heartbeat on or off
// - Heartbeat enable ignored in full duplex
// - Jabber enable, reset 1, switches jabber function on or off
// - Reserved read-only bits read 0 and ignore writes
// - Polarity reversed bit reads 1 while 10M polarity reversed; resets 0
// - Polarity bit driven by receive logic; software writes ignored
// - Nine power-down selects, reset 0, take power state from value bit
// - Power-down value 1 powers down selected functions, 0 normal
// - Force signal detect 1 makes 100M signal detect good
// - Autoneg power bit 0 saves power in autoneg, 1 full power
// - 10M transmit power bit 1 enters transmit power save
// - Crossover status reads 1 for crossed wiring, 0 straight
// - Crossover disable 0 keeps auto crossover, 1 uses manual value
// - With auto crossover off, status and wiring follow force value
// - Autoneg loopback bit loops digital autoneg logic back for test
module phy_tenbase_power_crossover_regs
   import phy_vendor_regs_pkg::*;
#(
   parameter int PD_COUNT = PD_SEL_WIDTH
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic ten_meg_i,
   input wire logic full_duplex_i,
   input wire logic polarity_reversed_i,
   input wire logic link_pulse_seen_i,
   input wire logic signal_detect_i,
   input wire logic auto_crossed_i,
   output logic link_pulse_tx_o,
   output logic link_good_o,
   output logic heartbeat_active_o,
   output logic squelch_normal_o,
   output logic jabber_active_o,
   output logic [PD_COUNT-1:0] pd_select_o,
   output logic [PD_COUNT-1:0] pd_power_down_o,
   output logic signal_detect_o,
   output logic autoneg_full_power_o,
   output logic ten_meg_tx_power_save_o,
   output logic crossover_o,
   output logic autoneg_loopback_o,
   output logic [3:0] vendor_select_o
);

   logic [15:0] tenbase_r;
   logic [15:0] tenbase_nxt;
   logic [PD_COUNT-1:0] pd_sel_r;
   logic [PD_COUNT-1:0] pd_sel_nxt;
   logic [15:0] spec_r;
   logic [15:0] spec_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic pol_meta_r;
   logic pol_sync_r;
   logic pulse_meta_r;
   logic pulse_sync_r;
   logic sd_meta_r;
   logic sd_sync_r;
   logic xover_meta_r;
   logic xover_sync_r;
   logic crossover_r;
   logic crossover_nxt;

   // Address decode for the three registers
   wire sel_ten = (addr_i == TENBASE_CONFIG_STATUS_ADDR);
   wire sel_pd = (addr_i == POWER_DOWN_TEST_CONTROL_ADDR);
   wire sel_spec = (addr_i == SPECIFIED_CONFIGURATION_ADDR);
   wire wr_ten = wr_i && sel_ten;
   wire wr_pd = wr_i && sel_pd;
   wire wr_spec = wr_i && sel_spec;

   // Only writable bits are stored; read-only positions stay zero
   assign tenbase_nxt = wr_ten ? (wdata_i & TENBASE_RW_MASK) : tenbase_r;
   assign pd_sel_nxt = wr_pd ? wdata_i[PD_COUNT-1:0] : pd_sel_r;
   assign spec_nxt = wr_spec ? (wdata_i & SPEC_RW_MASK) : spec_r;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tenbase_r <= TENBASE_RESET;
         pd_sel_r <= PD_SEL_RESET[PD_COUNT-1:0];
         spec_r <= SPEC_RESET;
      end else begin
         tenbase_r <= tenbase_nxt;
         pd_sel_r <= pd_sel_nxt;
         spec_r <= spec_nxt;
      end
   end

   // Pin-level status passes two flops before any logic sees it
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pol_meta_r <= 1'b0;
         pol_sync_r <= 1'b0;
         pulse_meta_r <= 1'b0;
         pulse_sync_r <= 1'b0;
         sd_meta_r <= 1'b0;
         sd_sync_r <= 1'b0;
         xover_meta_r <= 1'b0;
         xover_sync_r <= 1'b0;
      end else begin
         pol_meta_r <= polarity_reversed_i;
         pol_sync_r <= pol_meta_r;
         pulse_meta_r <= link_pulse_seen_i;
         pulse_sync_r <= pulse_meta_r;
         sd_meta_r <= signal_detect_i;
         sd_sync_r <= sd_meta_r;
         xover_meta_r <= auto_crossed_i;
         xover_sync_r <= xover_meta_r;
      end
   end

   // Control decode
   wire lp_on = tenbase_r[LINK_PULSE_ON_BIT];
   wire hb_on = tenbase_r[HEARTBEAT_ON_BIT];
   wire xover_dis = spec_r[CROSSOVER_DISABLE_BIT];
   wire xover_force = spec_r[CROSSOVER_FORCE_VALUE_BIT];
   wire pd_level = spec_r[POWER_DOWN_LEVEL_BIT];

   // Link pulse control only matters at 10M; at 100M the real link is used
   assign link_pulse_tx_o = ten_meg_i && lp_on;
   assign link_good_o = (ten_meg_i && !lp_on) ? 1'b1 : pulse_sync_r;
   // Heartbeat is meaningless without half duplex
   assign heartbeat_active_o = hb_on && ten_meg_i && !full_duplex_i;
   assign squelch_normal_o = tenbase_r[SQUELCH_NORMAL_BIT];
   assign jabber_active_o = tenbase_r[JABBER_GUARD_ON_BIT];
   assign pd_select_o = pd_sel_r;
   assign pd_power_down_o = pd_sel_r & {PD_COUNT{pd_level}};
   assign signal_detect_o = spec_r[FORCE_SIGNAL_DETECT_BIT] || sd_sync_r;
   assign autoneg_full_power_o = spec_r[AUTONEG_FULL_POWER_BIT];
   assign ten_meg_tx_power_save_o = spec_r[TEN_MEG_TX_POWER_SAVE_BIT];
   assign autoneg_loopback_o = spec_r[AUTONEG_LOOPBACK_BIT];
   assign vendor_select_o = {spec_r[VENDOR_TEST_SELECT_A_BIT],
                             spec_r[VENDOR_TEST_SELECT_B_BIT],
                             spec_r[MONITOR_SELECT_HI_BIT],
                             spec_r[MONITOR_SELECT_LO_BIT]};

   // Registered wiring so status and pin steering never disagree
   assign crossover_nxt = xover_dis ? xover_force : xover_sync_r;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         crossover_r <= 1'b0;
      end else begin
         crossover_r <= crossover_nxt;
      end
   end
   assign crossover_o = crossover_r;

   // Read mux; unmapped addresses read as zero
   wire [15:0] ten_view = tenbase_r | {15'h0000, pol_sync_r};
   wire [15:0] pd_view = {{(16-PD_COUNT){1'b0}}, pd_sel_r};
   wire [15:0] spec_view = spec_r | ({15'h0000, crossover_r} << CROSSOVER_STATUS_BIT);
   assign rdata_nxt = !rd_i ? 16'h0000 :
                      sel_ten ? ten_view :
                      sel_pd ? pd_view :
                      sel_spec ? spec_view : 16'h0000;

   // Read data stands for exactly the cycle after the strobe
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign rdata_o = rdata_r;

   // Checks below all wait out reset; they watch registers and outputs
   // Reserved read-only positions read as zero whatever was written
   a_ro_bits_zero: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      ($past(rd_i) && $past(sel_ten)) |->
         rdata_o[15] == 1'b0 && rdata_o[9:1] == 9'h000)
      else $error("reserved bits not zero");

   // Power-down register has nothing above the nine selects
   a_pd_high_zero: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      $past(rd_i) && $past(sel_pd) |-> rdata_o[15:9] == 7'h00)
      else $error("power-down reserved bits not zero");

   // Read data is zero outside the cycle after a read strobe
   a_rdata_idle: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      !$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside read cycle");

   // At 10M with pulses off the link is good and silent
   a_link_forced: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      (ten_meg_i && !tenbase_r[LINK_PULSE_ON_BIT]) |->
         link_good_o && !link_pulse_tx_o)
      else $error("link not forced good");

   // A write that turns pulses on takes effect on the next cycle
   a_link_write: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      (wr_ten && wdata_i[LINK_PULSE_ON_BIT] && ten_meg_i) ##1 ten_meg_i
         |-> link_pulse_tx_o)
      else $error("link pulses not enabled by write");

   // At 100M the pulse control steps aside and the real link shows
   a_link_100m: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      !ten_meg_i |-> !link_pulse_tx_o && link_good_o == pulse_sync_r)
      else $error("link control active at 100M");

   // Collision test never runs in full duplex
   a_heartbeat_fdx: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      full_duplex_i |-> !heartbeat_active_o)
      else $error("heartbeat in full duplex");

   // In 10M half duplex the heartbeat follows its enable bit
   a_heartbeat_hdx: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      (ten_meg_i && !full_duplex_i) |->
         heartbeat_active_o == tenbase_r[HEARTBEAT_ON_BIT])
      else $error("heartbeat not following enable");

   // Squelch and jabber controls take the written value next cycle
   a_squelch_write: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      wr_ten |=> squelch_normal_o == $past(wdata_i[SQUELCH_NORMAL_BIT]))
      else $error("squelch select not written");

   a_jabber_write: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      wr_ten |=> jabber_active_o == $past(wdata_i[JABBER_GUARD_ON_BIT]))
      else $error("jabber enable not written");

   // Polarity status comes only from the receiver, never from a write
   a_pol_follow: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      (rd_i && sel_ten) |=> rdata_o[0] == $past(pol_sync_r))
      else $error("polarity status wrong");

   a_pol_nowrite: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      wr_ten |=> tenbase_r[0] == 1'b0)
      else $error("polarity bit stored from write");

   // Each select written lands in its own output bit
   a_pd_sel_write: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      wr_pd |=> pd_select_o == $past(wdata_i[PD_COUNT-1:0]))
      else $error("power-down select not written");

   // A level of zero keeps every selected function running
   a_pd_level_low: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      !pd_level |-> pd_power_down_o == {PD_COUNT{1'b0}})
      else $error("power down with level low");

   // A level of one powers down exactly the selected functions
   a_pd_level_high: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      pd_level |-> pd_power_down_o == pd_select_o)
      else $error("power down not matching selects");

   // Selects then level, back to back: the gating uses both new values
   sequence pd_then_level_s;
      wr_pd ##1 wr_spec;
   endsequence
   a_pd_apply: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      pd_then_level_s |=> pd_power_down_o ==
         ($past(wdata_i[PD_COUNT-1:0], 2) & {PD_COUNT{$past(wdata_i[0])}}))
      else $error("power-down gating wrong");

   // Forced signal detect wins; otherwise the synchronised pin shows
   a_sd_force: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      spec_r[FORCE_SIGNAL_DETECT_BIT] |-> signal_detect_o)
      else $error("signal detect not forced");

   a_sd_real: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      !spec_r[FORCE_SIGNAL_DETECT_BIT] |-> signal_detect_o == sd_sync_r)
      else $error("signal detect not from pin");

   // Power-saving and loopback controls take the written value
   a_power_write: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      wr_spec |=> autoneg_full_power_o ==
         $past(wdata_i[AUTONEG_FULL_POWER_BIT]) &&
         ten_meg_tx_power_save_o ==
         $past(wdata_i[TEN_MEG_TX_POWER_SAVE_BIT]))
      else $error("power saving controls not written");

   a_loopback_write: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      wr_spec |=> autoneg_loopback_o ==
         $past(wdata_i[AUTONEG_LOOPBACK_BIT]))
      else $error("loopback control not written");

   a_vendor_write: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      wr_spec |=>
         vendor_select_o[3] == $past(wdata_i[VENDOR_TEST_SELECT_A_BIT]) &&
         vendor_select_o[2] == $past(wdata_i[VENDOR_TEST_SELECT_B_BIT]) &&
         vendor_select_o[1] == $past(wdata_i[MONITOR_SELECT_HI_BIT]) &&
         vendor_select_o[0] == $past(wdata_i[MONITOR_SELECT_LO_BIT]))
      else $error("vendor selects not written");

   // Status reads back the wiring actually applied
   a_xover_status: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      $past(rd_i) && $past(sel_spec) |->
         rdata_o[CROSSOVER_STATUS_BIT] == $past(crossover_r))
      else $error("crossover status wrong");

   // Manual setting applied two cycles after the disabling write
   sequence manual_xover_s;
      wr_spec && wdata_i[CROSSOVER_DISABLE_BIT] ##1 xover_dis [*2];
   endsequence
   a_xover_manual: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      manual_xover_s |-> crossover_o == xover_force)
      else $error("manual crossover not applied");

   // While disabled, the wiring keeps tracking the force value
   a_xover_hold: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      $past(xover_dis) |-> crossover_o == $past(xover_force))
      else $error("crossover not following force value");

   // Automatic mode follows the synchronised detector result
   a_xover_auto: assert property (@(posedge mclk_i)
      disable iff (rst_i)
      !$past(xover_dis) |-> crossover_o == $past(xover_sync_r))
      else $error("auto crossover not followed");

endmodule
`default_nettype wire

// >>> rtl/phy_vendor_regs_pkg.sv
package phy_vendor_regs_pkg;
   // Register indices in the PHY register space
   localparam logic [4:0] TENBASE_CONFIG_STATUS_ADDR = 5'h12;
   localparam logic [4:0] POWER_DOWN_TEST_CONTROL_ADDR = 5'h13;
   localparam logic [4:0] SPECIFIED_CONFIGURATION_ADDR = 5'h14;
   // 10BASE-T configuration/status fields
   localparam int LINK_PULSE_ON_BIT = 14;
   localparam int HEARTBEAT_ON_BIT = 13;
   localparam int SQUELCH_NORMAL_BIT = 12;
   localparam int JABBER_GUARD_ON_BIT = 11;
   localparam int TEN_RSVD_RW_BIT = 10;
   localparam int CABLE_POLARITY_REVERSED_BIT = 0;
   localparam logic [15:0] TENBASE_RW_MASK = 16'h7C00;
   localparam logic [15:0] TENBASE_RESET = 16'h7800;
   // Power-down test control: nine selects in bits 8..0
   localparam int PD_SEL_WIDTH = 9;
   localparam logic [8:0] PD_SEL_RESET = 9'h000;
   // Specified configuration fields
   localparam int VENDOR_TEST_SELECT_A_BIT = 15;
   localparam int VENDOR_TEST_SELECT_B_BIT = 14;
   localparam int FORCE_SIGNAL_DETECT_BIT = 13;
   localparam int VENDOR_TEST_SELECT_C_BIT = 12;
   localparam int AUTONEG_FULL_POWER_BIT = 11;
   localparam int TEN_MEG_TX_POWER_SAVE_BIT = 10;
   localparam int CROSSOVER_STATUS_BIT = 7;
   localparam int AUTONEG_LOOPBACK_BIT = 6;
   localparam int CROSSOVER_FORCE_VALUE_BIT = 5;
   localparam int CROSSOVER_DISABLE_BIT = 4;
   localparam int MONITOR_SELECT_HI_BIT = 3;
   localparam int MONITOR_SELECT_LO_BIT = 2;
   localparam int SPEC_RSVD_RW_BIT = 1;
   localparam int POWER_DOWN_LEVEL_BIT = 0;
   // Bits 9:8 are reserved read-write storage
   localparam logic [15:0] SPEC_RW_MASK = 16'hFF7F;
   localparam logic [15:0] SPEC_RESET = 16'h0000;
endpackage

// >>> bench/test_phy_tenbase_power_crossover_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_phy_tenbase_power_crossover_regs;
   import phy_vendor_regs_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] addr_i = 5'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic ten_meg = 1'b1;
   logic full_dup = 1'b0;
   logic pol_rev = 1'b0;
   logic link_seen = 1'b0;
   logic sig_det = 1'b0;
   logic auto_x = 1'b0;
   logic [15:0] rdata;
   logic lp_tx, lgood, hb, sq, jab, sd, anfp, txps, xover, anlb;
   logic [3:0] vsel;
   logic [8:0] pd_sel, pd_dn;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   // Packed view of the single-bit controls, so one compare covers them all
   wire logic [15:0] st = {2'b00, lp_tx, lgood, hb, sq, jab, sd, anfp, txps,
      xover, anlb, vsel};

   // Free-running 10 MHz clock
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end

   phy_tenbase_power_crossover_regs i_phy_tenbase_power_crossover_regs (
      .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .ten_meg_i(ten_meg),
      .full_duplex_i(full_dup), .polarity_reversed_i(pol_rev),
      .link_pulse_seen_i(link_seen), .signal_detect_i(sig_det),
      .auto_crossed_i(auto_x), .link_pulse_tx_o(lp_tx), .link_good_o(lgood),
      .heartbeat_active_o(hb), .squelch_normal_o(sq), .jabber_active_o(jab),
      .pd_select_o(pd_sel), .pd_power_down_o(pd_dn), .signal_detect_o(sd),
      .autoneg_full_power_o(anfp), .ten_meg_tx_power_save_o(txps),
      .crossover_o(xover), .autoneg_loopback_o(anlb), .vendor_select_o(vsel));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe; the register holds the value from the next edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(rdata, e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   // Hang guard: the sequence needs well under 300 cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         end_sim();
      end
   end

   initial begin
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(5'h12, 16'h7800);
      rd(5'h13, 16'h0000);
      rd(5'h14, 16'h0000);
      settle(1);
      chk(st, 16'h2E00);
      // Reserved read-write bits TEN_RSVD_RW_BIT and SPEC_RSVD_RW_BIT are always written as zero
      wr(5'h12, 16'hFBFF);
      rd(5'h12, 16'h7800);
      wr(5'h12, 16'h0000);
      settle(1);
      chk(st, 16'h1000);
      wr(5'h12, 16'h6000);
      settle(1);
      chk(st, 16'h2800);
      @(posedge mclk_i);
      full_dup <= 1'b1;
      settle(1);
      chk(st, 16'h2000);
      // At 100M the link controls step aside and the real status shows
      @(posedge mclk_i);
      ten_meg <= 1'b0;
      link_seen <= 1'b1;
      settle(4);
      chk(st, 16'h1000);
      @(posedge mclk_i);
      ten_meg <= 1'b1;
      full_dup <= 1'b0;
      link_seen <= 1'b0;
      pol_rev <= 1'b1;
      settle(4);
      rd(5'h12, 16'h6001);
      wr(5'h13, 16'hFFFF);
      rd(5'h13, 16'h01FF);
      chk({7'h00, pd_dn}, 16'h0000);
      wr(5'h14, 16'h0001);
      settle(1);
      chk({7'h00, pd_dn}, 16'h01FF);
      wr(5'h13, 16'h0105);
      settle(1);
      chk({7'h00, pd_sel}, 16'h0105);
      chk({7'h00, pd_dn}, 16'h0105);
      // Two writes with no gap: selects, then the level in the next cycle
      @(posedge mclk_i);
      addr_i <= 5'h13;
      wdata_i <= 16'h00F0;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      addr_i <= 5'h14;
      wdata_i <= 16'h0001;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      settle(1);
      chk({7'h00, pd_dn}, 16'h00F0);
      // Manual crossover forced to crossed; status bit comes back set
      wr(5'h14, 16'hFFFD);
      settle(1);
      rd(5'h14, 16'hFFFD);
      chk(st, 16'h29FF);
      wr(5'h14, 16'h0000);
      settle(1);
      chk(st, 16'h2800);
      @(posedge mclk_i);
      auto_x <= 1'b1;
      sig_det <= 1'b1;
      settle(5);
      chk(st, 16'h2920);
      rd(5'h14, 16'h0080);
      wr(5'h14, 16'h0010);
      settle(1);
      chk(st, 16'h2900);
      rd(5'h14, 16'h0010);
      // Unmapped index: reads zero and the write lands nowhere
      wr(5'h15, 16'hFFFF);
      rd(5'h15, 16'h0000);
      rd(5'h14, 16'h0010);
      end_sim();
   end
endmodule
`default_nettype wire
